/* design/dcc_pkg.sv */
// Purpose: shared constants and types for the dma channel control block
// Assumes: 32-bit axi4-lite register bus, 16-bit system data bus
// Notes: register offsets are byte addresses, one aligned word each
package dcc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SRC = 8'h04;
    localparam logic [7:0] OFF_DST = 8'h08;
    localparam logic [7:0] OFF_CNT = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;
    // control field positions
    localparam int CTL_CHANNEL_ENABLE = 0;
    localparam int CTL_SIZE = 1;
    localparam int CTL_TRM_LO = 2;
    localparam int CTL_DAM_LO = 4;
    localparam int CTL_SAM_LO = 6;
    localparam int CTL_SOFTWARE_TRANSFER_REQUEST = 8;
    localparam int CTL_RELOAD = 9;
    localparam int CTL_DUMMY_WRITE_MODE = 10;
    // value after reset and bus response codes
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // address step modes
    localparam logic [1:0] AM_FIXED = 2'h0;
    localparam logic [1:0] AM_INC = 2'h1;
    localparam logic [1:0] AM_DEC = 2'h2;
    localparam logic [1:0] AM_PIA = 2'h3;
    // transfer modes
    localparam logic [1:0] TM_ONESHOT = 2'h0;
    localparam logic [1:0] TM_REP_ONESHOT = 2'h1;
    localparam logic [1:0] TM_CONT = 2'h2;
    localparam logic [1:0] TM_REP_CONT = 2'h3;
    // data buffer shape
    localparam int FIFO_WIDTH = 16;
    localparam int FIFO_DEPTH = 16;
    // one-hot channel sequencer states
    typedef enum logic [3:0] {
        DCC_IDLE = 4'h1,
        DCC_RD = 4'h2,
        DCC_WR = 4'h4,
        DCC_NUL = 4'h8
    } dcc_state_t;
endpackage : dcc_pkg

/* design/dcc_channel.sv */
// Purpose: one dma channel: control register, address stepping, reload, bus sequencer
// Assumes: 50 MHz clk_i, memory port holds mem_req_o until mem_ack_i
// Notes: read data passes through a 16-word buffer before being written
//
// How it works
// RULE1 - with dummy write mode set, each destination write is followed by a dummy source write.
// RULE2 - with the reload bit set, source, destination and count restore at the next start.
// RULE3 - repeated modes always restore the count at the end of a block.
// RULE4 - only the original count is kept; the original addresses are computed back from it.
// RULE5 - software sets the request bit to start and hardware clears it on completion.
// RULE6 - the transfer mode decides how many transfers one request performs.
// RULE7 - the source step mode keeps, increments, decrements or holds (indirect) the source.
// RULE8 - the destination step mode does the same for the destination address.
// RULE9 - the transfer mode field picks one-shot, repeated one-shot, continuous or repeated.
// RULE10 - the size bit selects byte transfers when set and word transfers when clear.
// RULE11 - transfers only run while the channel enable bit is set.
// RULE12 - a stepping address moves by one for bytes and by two for words.
// RULE13 - control bits 15 to 11 always read as zero.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps

module dcc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] fill;
    logic push;
    logic pop;

    // full and empty come from the fill count, never guessed
    assign in_ready_o = (fill != (AW+1)'(DEPTH));
    assign out_valid_o = (fill != '0);
    assign out_data_o = mem[rp];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // pointer and storage update, frozen while ce_i is low
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wp <= '0;
            rp <= '0;
            fill <= '0;
        end else if (ce_i) begin
            if (push) begin
                mem[wp] <= in_data_i;
                wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
            end
            if (pop) begin
                rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
            end
            fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : dcc_fifo

module dcc_channel (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic trig_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic mem_byte_o,
    output logic [15:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic [15:0] mem_rdata_i,
    output logic busy_o
);
    typedef struct packed {
        logic dummy_write_mode;
        logic reload;
        logic software_transfer_request;
        logic [1:0] source_address_step_mode;
        logic [1:0] destination_address_step_mode;
        logic [1:0] transfer_mode_select;
        logic size;
        logic channel_enable;
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] cnt;
        logic [15:0] orig;
        logic fin;
        dcc_pkg::dcc_state_t st;
        logic awrdy;
        logic wrdy;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arrdy;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic req;
        logic we;
        logic [15:0] addr;
        logic [15:0] mwdata;
        logic busy;
    } dcc_regs_t;

    dcc_regs_t q;
    dcc_regs_t next_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [15:0] fifo_out_data;
    logic fifo_push;

    // control word as software sees it, upper bits forced low
    function automatic logic [15:0] dcc_ctl_word(input dcc_regs_t r);
        dcc_ctl_word = {5'h00, r.dummy_write_mode, r.reload, r.software_transfer_request, r.source_address_step_mode, r.destination_address_step_mode,
                        r.transfer_mode_select, r.size, r.channel_enable}; // RULE13
    endfunction : dcc_ctl_word

    // byte-lane merge for 16-bit registers
    function automatic logic [15:0] dcc_merge(input logic [15:0] old,
                                              input logic [31:0] d, input logic [3:0] s);
        dcc_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : dcc_merge

    // address after one transfer; indirect and fixed modes hold
    function automatic logic [15:0] dcc_step(input logic [15:0] a, input logic [1:0] m,
                                             input logic byte_sz);
        logic [15:0] d;
        d = byte_sz ? 16'h0001 : 16'h0002; // RULE12 RULE10
        unique case (m)
            dcc_pkg::AM_INC: dcc_step = a + d;
            dcc_pkg::AM_DEC: dcc_step = a - d;
            default: dcc_step = a;
        endcase
    endfunction : dcc_step

    // original address recovered from transfers done, no stored copy
    function automatic logic [15:0] dcc_restore(input logic [15:0] a, input logic [1:0] m,
                                                input logic byte_sz, input logic [15:0] el);
        logic [15:0] off;
        off = byte_sz ? el : {el[14:0], 1'b0};
        unique case (m)
            dcc_pkg::AM_INC: dcc_restore = a - off; // RULE4
            dcc_pkg::AM_DEC: dcc_restore = a + off;
            default: dcc_restore = a;
        endcase
    endfunction : dcc_restore

    assign fifo_push = (q.st == dcc_pkg::DCC_RD) & q.req & mem_ack_i;
    assign fifo_pop = (q.st == dcc_pkg::DCC_WR) & q.req & mem_ack_i;

    // read data is parked here; a full buffer holds off the next read
    dcc_fifo #(.WIDTH(dcc_pkg::FIFO_WIDTH), .DEPTH(dcc_pkg::FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .in_valid_i(fifo_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(mem_rdata_i),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_out_data)
    );

    // whole next state: sequencer first, then software access on top
    always_comb begin
        logic done;
        logic blk_end;
        logic [15:0] el;
        next_q = q;
        done = 1'b0;
        blk_end = 1'b0;
        el = q.orig - q.cnt;
        unique case (q.st)
            dcc_pkg::DCC_IDLE: begin
                if (q.channel_enable && (q.software_transfer_request || trig_i)) begin // RULE11 RULE5
                    if (q.fin && q.reload) begin
                        next_q.src = dcc_restore(q.src, q.source_address_step_mode, q.size, el); // RULE2
                        next_q.dst = dcc_restore(q.dst, q.destination_address_step_mode, q.size, el);
                        next_q.cnt = q.orig;
                        next_q.fin = 1'b0;
                    end
                    if ((q.cnt != 16'h0000 || (q.fin && q.reload)) && fifo_in_ready) begin
                        next_q.st = dcc_pkg::DCC_RD;
                        next_q.req = 1'b1;
                        next_q.we = 1'b0;
                        next_q.addr = (q.fin && q.reload) ?
                            dcc_restore(q.src, q.source_address_step_mode, q.size, el) : q.src;
                    end
                end
            end
            dcc_pkg::DCC_RD: begin
                if (q.req && mem_ack_i) begin
                    next_q.req = 1'b0;
                    next_q.st = dcc_pkg::DCC_WR;
                end
            end
            dcc_pkg::DCC_WR: begin
                if (!q.req && fifo_out_valid) begin
                    next_q.req = 1'b1;
                    next_q.we = 1'b1;
                    next_q.addr = q.dst;
                    next_q.mwdata = fifo_out_data;
                end else if (q.req && mem_ack_i) begin
                    next_q.req = 1'b0;
                    if (q.dummy_write_mode) begin
                        next_q.st = dcc_pkg::DCC_NUL; // RULE1
                        next_q.req = 1'b1;
                        next_q.addr = q.src;
                    end else begin
                        done = 1'b1;
                    end
                end
            end
            dcc_pkg::DCC_NUL: begin
                if (q.req && mem_ack_i) begin
                    next_q.req = 1'b0;
                    done = 1'b1;
                end
            end
            default: begin
                next_q.st = dcc_pkg::DCC_IDLE;
                next_q.req = 1'b0;
            end
        endcase
        // one transfer finished: step both addresses and count down
        if (done) begin
            next_q.st = dcc_pkg::DCC_IDLE;
            next_q.we = 1'b0;
            next_q.src = dcc_step(q.src, q.source_address_step_mode, q.size); // RULE7
            next_q.dst = dcc_step(q.dst, q.destination_address_step_mode, q.size); // RULE8
            next_q.cnt = q.cnt - 16'h0001;
            blk_end = (q.cnt == 16'h0001);
            // one-shot modes finish a request per transfer, continuous per block
            if (!q.transfer_mode_select[1] || blk_end) begin // RULE6 RULE9
                next_q.software_transfer_request = 1'b0; // RULE5
            end
            if (blk_end && q.transfer_mode_select[0]) begin
                next_q.cnt = q.orig; // RULE3
                if (q.reload) begin
                    next_q.src = dcc_restore(dcc_step(q.src, q.source_address_step_mode, q.size),
                                             q.source_address_step_mode, q.size, q.orig); // RULE2 RULE4
                    next_q.dst = dcc_restore(dcc_step(q.dst, q.destination_address_step_mode, q.size),
                                             q.destination_address_step_mode, q.size, q.orig);
                end
            end else if (blk_end) begin
                next_q.channel_enable = 1'b0;
                next_q.fin = 1'b1;
            end
        end
        // write channel: address and data taken in either order
        if (s_axi_awvalid && q.awrdy) begin
            next_q.aw_have = 1'b1;
            next_q.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wrdy) begin
            next_q.w_have = 1'b1;
            next_q.wdata = s_axi_wdata;
            next_q.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            next_q.bvalid = 1'b0;
        end
        // software write lands after hardware, so a set request wins
        if (q.aw_have && q.w_have && !q.bvalid) begin
            next_q.aw_have = 1'b0;
            next_q.w_have = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = dcc_pkg::RESP_OKAY;
            unique case (q.awaddr)
                dcc_pkg::OFF_CTRL: begin
                    if (q.wstrb[0]) begin
                        {next_q.source_address_step_mode, next_q.destination_address_step_mode, next_q.transfer_mode_select,
                         next_q.size, next_q.channel_enable} = q.wdata[7:0];
                    end
                    if (q.wstrb[1]) begin
                        next_q.dummy_write_mode = q.wdata[dcc_pkg::CTL_DUMMY_WRITE_MODE];
                        next_q.reload = q.wdata[dcc_pkg::CTL_RELOAD];
                        next_q.software_transfer_request = q.wdata[dcc_pkg::CTL_SOFTWARE_TRANSFER_REQUEST];
                    end
                end
                dcc_pkg::OFF_SRC: next_q.src = dcc_merge(q.src, q.wdata, q.wstrb);
                dcc_pkg::OFF_DST: next_q.dst = dcc_merge(q.dst, q.wdata, q.wstrb);
                dcc_pkg::OFF_CNT: begin
                    next_q.cnt = dcc_merge(q.cnt, q.wdata, q.wstrb);
                    next_q.orig = dcc_merge(q.cnt, q.wdata, q.wstrb);
                    // a block ending in this very cycle keeps its finished flag
                    next_q.fin = next_q.fin && !q.fin;
                end
                dcc_pkg::OFF_STAT: next_q.bresp = dcc_pkg::RESP_OKAY;
                default: next_q.bresp = dcc_pkg::RESP_SLVERR;
            endcase
        end
        next_q.awrdy = !next_q.aw_have && !next_q.bvalid;
        next_q.wrdy = !next_q.w_have && !next_q.bvalid;
        // read channel: one read in flight, answered the cycle after it is taken
        if (q.rvalid && s_axi_rready) begin
            next_q.rvalid = 1'b0;
            next_q.arrdy = 1'b1;
        end
        if (s_axi_arvalid && q.arrdy) begin
            next_q.arrdy = 1'b0;
            next_q.rvalid = 1'b1;
            next_q.rresp = dcc_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                dcc_pkg::OFF_CTRL: next_q.rdata = {16'h0000, dcc_ctl_word(q)}; // RULE13
                dcc_pkg::OFF_SRC: next_q.rdata = {16'h0000, q.src};
                dcc_pkg::OFF_DST: next_q.rdata = {16'h0000, q.dst};
                dcc_pkg::OFF_CNT: next_q.rdata = {16'h0000, q.cnt};
                dcc_pkg::OFF_STAT: next_q.rdata = {26'h0000000, q.st, q.fin,
                                                   q.st != dcc_pkg::DCC_IDLE};
                default: begin
                    next_q.rdata = 32'h00000000;
                    next_q.rresp = dcc_pkg::RESP_SLVERR;
                end
            endcase
        end
        // busy kept in a flop so the pin carries no decode glitches
        next_q.busy = (next_q.st != dcc_pkg::DCC_IDLE);
    end

    // single state register; clock enable freezes everything
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '0;
            q.st <= dcc_pkg::DCC_IDLE;
            q.awrdy <= 1'b1;
            q.wrdy <= 1'b1;
            q.arrdy <= 1'b1;
        end else if (ce_i) begin
            q <= next_q;
        end
    end

    // every output straight from the state register
    assign s_axi_awready = q.awrdy;
    assign s_axi_wready = q.wrdy;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arrdy;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.rdata;
    assign mem_req_o = q.req;
    assign mem_we_o = q.we;
    assign mem_byte_o = q.size; // RULE10
    assign mem_addr_o = q.addr;
    assign mem_wdata_o = q.mwdata;
    assign busy_o = q.busy;

    sequence s_dst_write_done;
        ce_i && q.st == dcc_pkg::DCC_WR && q.req && mem_ack_i;
    endsequence

    sequence s_dummy_issued;
        q.st == dcc_pkg::DCC_NUL && q.req && q.we && q.addr == $past(q.src);
    endsequence

    a_null_write_follows: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE1
        s_dst_write_done and q.dummy_write_mode |=> s_dummy_issued)
        else $error("dummy write not issued after destination write");

    a_no_null_write: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE1
        s_dst_write_done and !q.dummy_write_mode |=> q.st == dcc_pkg::DCC_IDLE && !q.req)
        else $error("unexpected dummy write");

    a_idle_when_off: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE11
        q.st == dcc_pkg::DCC_IDLE && !q.channel_enable && !(q.aw_have && q.w_have) |=> !q.req)
        else $error("transfer started while channel disabled");

    a_src_byte_inc: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE12
        s_dst_write_done and !q.dummy_write_mode && q.source_address_step_mode == dcc_pkg::AM_INC && q.size
        && q.cnt != 16'h0001 && !(q.aw_have && q.w_have) |=> q.src == $past(q.src) + 16'h0001)
        else $error("source byte increment wrong");

    a_dst_word_dec: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE8
        s_dst_write_done and !q.dummy_write_mode && q.destination_address_step_mode == dcc_pkg::AM_DEC && !q.size
        && q.cnt != 16'h0001 && !(q.aw_have && q.w_have) |=> q.dst == $past(q.dst) - 16'h0002)
        else $error("destination word decrement wrong");

    a_oneshot_clears_req: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE5
        s_dst_write_done and !q.dummy_write_mode && !q.transfer_mode_select[1] && !(q.aw_have && q.w_have)
        |=> !q.software_transfer_request)
        else $error("request bit not cleared after one-shot transfer");

    a_repeat_count_back: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE3
        s_dst_write_done and !q.dummy_write_mode && q.transfer_mode_select[0] && q.cnt == 16'h0001
        && !(q.aw_have && q.w_have) |=> q.cnt == q.orig && q.channel_enable)
        else $error("count not restored in repeated mode");

    a_ctl_upper_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE13
        s_axi_arvalid && q.arrdy && s_axi_araddr == dcc_pkg::OFF_CTRL && ce_i
        |=> s_axi_rvalid && s_axi_rdata[15:11] == 5'h00)
        else $error("control upper bits not zero");
endmodule : dcc_channel

/* sim/dcc_mem_model.sv */
// Purpose: behavioural memory on the channel's system bus side
// Assumes: one access at a time, request held until acknowledged
// Notes: address bit 2 set gives a slow answer; read data is derived from the address
`timescale 1ns/100ps

module dcc_mem_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic ack_o,
    output logic [15:0] rdata_o,
    output logic [15:0] n_wr_o,
    output logic [15:0] last_waddr_o,
    output logic [15:0] last_wdata_o
);
    logic [2:0] wait_q;
    logic [15:0] pat_q;
    // idle pattern flips each cycle so stale read data never passes as valid
    assign rdata_o = ack_o ? (addr_i ^ 16'h5a5a) : pat_q;
    // acknowledge after 0 or 3 wait cycles, log every accepted write
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_o <= 1'b0;
            wait_q <= 3'h0;
            pat_q <= 16'h0000;
            n_wr_o <= 16'h0000;
            last_waddr_o <= 16'h0000;
            last_wdata_o <= 16'h0000;
        end else begin
            pat_q <= ~pat_q;
            ack_o <= req_i && !ack_o && wait_q == (addr_i[2] ? 3'h3 : 3'h0);
            wait_q <= (req_i && !ack_o) ? wait_q + 3'h1 : 3'h0;
            if (req_i && ack_o && we_i) begin
                n_wr_o <= n_wr_o + 16'h0001;
                last_waddr_o <= addr_i;
                last_wdata_o <= wdata_i;
            end
        end
    end
endmodule : dcc_mem_model

/* sim/dcc_channel_bench.sv */
// Purpose: self-checking bench for the dma channel control block
// Assumes: axi4-lite master tasks, behavioural memory on the system bus
// Notes: ce_i tied high, trig_i tied low; only software requests start transfers
`timescale 1ns/100ps

module dcc_channel_bench;
    localparam logic [7:0] CTL = dcc_pkg::OFF_CTRL, SRC = dcc_pkg::OFF_SRC;
    localparam logic [7:0] DST = dcc_pkg::OFF_DST, CNT = dcc_pkg::OFF_CNT;
    logic clk_i = 1'b0, rst_b_i = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd_q;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, req, we, ack, busy, mbyte;
    logic [1:0] bresp, rresp;
    logic [15:0] addr, mwdata, mrdata, n_wr, lw_a, lw_d;
    int n_mismatch = 0;
    int n_tests = 0;

    always #10 clk_i = ~clk_i;

    dcc_channel u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .trig_i(1'b0),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mem_req_o(req), .mem_we_o(we),
        .mem_byte_o(mbyte), .mem_addr_o(addr), .mem_wdata_o(mwdata), .mem_ack_i(ack),
        .mem_rdata_i(mrdata), .busy_o(busy));

    dcc_mem_model u_mem (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .we_i(we),
        .addr_i(addr), .wdata_i(mwdata), .ack_o(ack), .rdata_o(mrdata), .n_wr_o(n_wr),
        .last_waddr_o(lw_a), .last_wdata_o(lw_d));

    // verdict and end of run
    task automatic summarize;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic hang;
        n_mismatch++;
        $display("ERROR %0t wait ran out", $time);
        summarize();
    endtask : hang

    // address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        int i;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge clk_i);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
                break;
        end
        if (i == 64)
            hang();
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        int i;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge clk_i);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
                break;
        end
        if (i == 64)
            hang();
        rd_q = rdata;
        rready <= 1'b0;
        chk({30'h0, rresp}, {30'h0, er});
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        rd(a, dcc_pkg::RESP_OKAY);
        chk(rd_q, {16'h0000, e});
    endtask : rchk

    // sequencer idle for six cycles in a row means the request is finished
    task automatic settle;
        int i, q;
        q = 0;
        for (i = 0; i < 400 && q < 6; i++) begin
            @(posedge clk_i);
            q = (busy === 1'b0) ? q + 1 : 0;
        end
        if (q < 6)
            hang();
    endtask : settle

    task automatic run(input logic [15:0] s, d, c, ctl);
        wr(SRC, s, dcc_pkg::RESP_OKAY);
        wr(DST, d, dcc_pkg::RESP_OKAY);
        wr(CNT, c, dcc_pkg::RESP_OKAY);
        wr(CTL, ctl, dcc_pkg::RESP_OKAY);
        settle();
    endtask : run

    // memory side results: writes seen, last write address and data
    task automatic mchk(input logic [15:0] n, a, d);
        chk({16'h0, n_wr}, {16'h0, n});
        chk({16'h0, lw_a}, {16'h0, a});
        chk({16'h0, lw_d}, {16'h0, d});
    endtask : mchk

    task automatic regs(input logic [15:0] ctl, s, d, c);
        rchk(CTL, ctl);
        rchk(SRC, s);
        rchk(DST, d);
        rchk(CNT, c);
    endtask : regs

    initial begin
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        regs(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        // unmapped place is refused without effect
        wr(8'h20, 16'h1234, dcc_pkg::RESP_SLVERR);
        rd(8'h20, dcc_pkg::RESP_SLVERR);
        chk(rd_q, 32'h0);
        wr(CTL, 16'heefe, dcc_pkg::RESP_OKAY);
        rchk(CTL, 16'h06fe);
        wr(CTL, 16'h0000, dcc_pkg::RESP_OKAY);
        // word, both increment, one-shot: one transfer per request
        run(16'h0100, 16'h0200, 16'h0002, 16'h0151);
        regs(16'h0051, 16'h0102, 16'h0202, 16'h0001);
        mchk(16'h0001, 16'h0200, 16'h5b5a);
        wr(CTL, 16'h0151, dcc_pkg::RESP_OKAY);
        settle();
        regs(16'h0050, 16'h0104, 16'h0204, 16'h0000);
        mchk(16'h0002, 16'h0202, 16'h5b58);
        rchk(8'h10, 16'h0006);
        chk({31'h0, mbyte}, 32'h0);
        // byte, source up, destination down, continuous: whole block on one request
        run(16'h0300, 16'h0400, 16'h0003, 16'h016b);
        regs(16'h006a, 16'h0303, 16'h03fd, 16'h0000);
        chk({16'h0, n_wr}, 32'h5);
        chk({31'h0, mbyte}, 32'h1);
        // reload restores addresses and count, then the block runs again
        wr(CTL, 16'h036b, dcc_pkg::RESP_OKAY);
        settle();
        chk({16'h0, n_wr}, 32'h8);
        chk({16'h0, lw_a}, 32'h3fe);
        regs(16'h026a, 16'h0303, 16'h03fd, 16'h0000);
        // dummy write mode, indirect source, fixed destination
        run(16'h0500, 16'h0600, 16'h0001, 16'h05c1);
        mchk(16'h000a, 16'h0500, 16'h5f5a);
        regs(16'h04c0, 16'h0500, 16'h0600, 16'h0000);
        // repeated one-shot: count comes back, channel stays enabled
        run(16'h0704, 16'h0800, 16'h0001, 16'h0155);
        regs(16'h0055, 16'h0706, 16'h0802, 16'h0001);
        chk({16'h0, n_wr}, 32'hb);
        // repeated continuous, word destination stepping down
        run(16'h0900, 16'h0a00, 16'h0002, 16'h016d);
        regs(16'h006d, 16'h0904, 16'h09fc, 16'h0002);
        chk({16'h0, n_wr}, 32'hd);
        // disabled channel ignores a pending request
        run(16'h0b00, 16'h0c00, 16'h0001, 16'h0100);
        chk({16'h0, n_wr}, 32'hd);
        rchk(CTL, 16'h0100);
        summarize();
    end
endmodule : dcc_channel_bench
